// ==== rtl/input_debounce_and_force_consts.vh ====
// Constants for the input debounce and force block
`ifndef INPUT_DEBOUNCE_AND_FORCE_CONSTS_VH
`define INPUT_DEBOUNCE_AND_FORCE_CONSTS_VH

// Register byte addresses
`define ADDR_FILTERED_INPUT_STATUS 4'h0
`define ADDR_INPUT_FORCE_MASK 4'h4
`define ADDR_FORCED_INPUT_VALUES 4'h8
`define ADDR_W 4

// Field layout
`define NUM_INPUTS 6
`define INPUT_MSB 5
`define REG_W 16
`define RSVD_W 10
`define RSVD_ZERO 10'h000
`define INPUTS_ZERO 6'h00
`define STATUS_PAD 16'h0000
`define FORCE_PAD 26'h0000000
`define WORD_ZERO 32'h00000000
`define STRB_ZERO 4'h0
`define STRB_LOW_LANE 0

// Reset values
`define FORCE_MASK_RESET 6'h00
`define FORCED_VALUES_RESET 6'h00
`define STATUS_RESET 6'h00

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// Timing: one millisecond of 10 ns clock cycles per sample
`define SAMPLE_CYCLES_DEFAULT 17'h186a0
`define CNT_W 17
`define CNT_ZERO 17'h00000
`define CNT_ONE 17'h00001

`endif

// ==== rtl/input_debounce_and_force.v ====
// Debounced six-line input status with software force, AXI4-Lite regs
`timescale 1ns/10ps
`default_nettype none
`include "input_debounce_and_force_consts.vh"

module input_debounce_and_force #(
  parameter [`CNT_W-1:0] SAMPLE_CYCLES = `SAMPLE_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire I_CLK_SYS,
  input wire I_RST_N,
  // Field input lines, bit n is line n plus one
  input wire [`INPUT_MSB:0] I_INPUT_LINES,
  // Filtered status
  output wire [`REG_W-1:0] O_FILTERED_STATUS,
  // AXI4-Lite write address
  input wire [`ADDR_W-1:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  // AXI4-Lite write data
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  // AXI4-Lite write response
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  // AXI4-Lite read address
  input wire [`ADDR_W-1:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  // AXI4-Lite read data
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY
);

  reg [`INPUT_MSB:0] sync_a;
  reg [`INPUT_MSB:0] sync_b;
  reg [`INPUT_MSB:0] force_mask;
  reg [`INPUT_MSB:0] forced_input_values;
  reg [`INPUT_MSB:0] last_sample;
  reg [`INPUT_MSB:0] filtered;
  reg [`CNT_W-1:0] tick_cnt;
  reg aw_held;
  reg w_held;
  reg [`ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire sample_tick;
  wire [`INPUT_MSB:0] effective;
  wire do_write;
  wire do_read;
  wire [`INPUT_MSB:0] agree;
  wire sel_mask;
  wire sel_values;
  wire lane_low;
  reg [`INPUT_MSB:0] next_filtered;
  reg [1:0] next_bresp;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  // Two-stage synchroniser on the field lines
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync_a <= `INPUTS_ZERO;
      sync_b <= `INPUTS_ZERO;
    end else begin
      sync_a <= I_INPUT_LINES;
      sync_b <= sync_a;
    end
  end

  // Forced value replaces the line where its mask bit is set
  assign effective = (force_mask & forced_input_values) |
                     (~force_mask & sync_b);

  // Millisecond sample strobe
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_cnt <= `CNT_ZERO;
    end else if (sample_tick) begin
      tick_cnt <= `CNT_ZERO;
    end else begin
      tick_cnt <= tick_cnt + `CNT_ONE;
    end
  end
  assign sample_tick = (tick_cnt == SAMPLE_CYCLES - `CNT_ONE);

  // Bits whose new sample repeats the one taken a period earlier
  assign agree = ~(effective ^ last_sample);

  // A lone differing sample leaves the old level in place
  always @* begin
    next_filtered = filtered;
    if (sample_tick) begin
      next_filtered = (effective & agree) | (filtered & ~agree);
    end
  end

  // Filtered level moves only on a sample tick
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      last_sample <= `STATUS_RESET;
      filtered <= `STATUS_RESET;
    end else begin
      if (sample_tick) begin
        last_sample <= effective;
      end
      filtered <= next_filtered;
    end
  end

  // Status word, reserved upper bits zero
  assign O_FILTERED_STATUS = {`RSVD_ZERO, filtered};

  // Write channel: address and data taken in either order
  assign O_AWREADY = !aw_held && !O_BVALID;
  assign O_WREADY = !w_held && !O_BVALID;
  assign do_write = aw_held && w_held && !O_BVALID;

  // Write target decode; the force fields sit in the low byte lane
  assign sel_mask = (aw_addr == `ADDR_INPUT_FORCE_MASK);
  assign sel_values = (aw_addr == `ADDR_FORCED_INPUT_VALUES);
  assign lane_low = w_strb[`STRB_LOW_LANE];

  // Write response code, status offset accepted but ignored
  always @* begin
    case (aw_addr)
      `ADDR_FILTERED_INPUT_STATUS: next_bresp = `RESP_OKAY;
      `ADDR_INPUT_FORCE_MASK: next_bresp = `RESP_OKAY;
      `ADDR_FORCED_INPUT_VALUES: next_bresp = `RESP_OKAY;
      default: next_bresp = `RESP_DECERR;
    endcase
  end

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`ADDR_W{1'b0}};
      w_data <= `WORD_ZERO;
      w_strb <= `STRB_ZERO;
      O_BVALID <= 1'b0;
      O_BRESP <= `RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_held <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= next_bresp;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Force registers, cleared at every reset
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      force_mask <= `FORCE_MASK_RESET;
      forced_input_values <= `FORCED_VALUES_RESET;
    end else if (do_write && lane_low) begin
      if (sel_mask) begin
        force_mask <= w_data[`INPUT_MSB:0];
      end
      if (sel_values) begin
        forced_input_values <= w_data[`INPUT_MSB:0];
      end
    end
  end

  // Read channel: one-cycle registered answer
  assign O_ARREADY = !O_RVALID;
  assign do_read = I_ARVALID && O_ARREADY;

  // Read data select, unmapped offsets answer a decode error
  always @* begin
    next_rdata = `WORD_ZERO;
    next_rresp = `RESP_OKAY;
    case (I_ARADDR)
      `ADDR_FILTERED_INPUT_STATUS: begin
        next_rdata = {`STATUS_PAD, O_FILTERED_STATUS};
      end
      `ADDR_INPUT_FORCE_MASK: begin
        next_rdata = {`FORCE_PAD, force_mask};
      end
      `ADDR_FORCED_INPUT_VALUES: begin
        next_rdata = {`FORCE_PAD, forced_input_values};
      end
      default: begin
        next_rresp = `RESP_DECERR;
      end
    endcase
  end

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RVALID <= 1'b0;
      O_RDATA <= `WORD_ZERO;
      O_RRESP <= `RESP_OKAY;
    end else if (do_read) begin
      O_RVALID <= 1'b1;
      O_RDATA <= next_rdata;
      O_RRESP <= next_rresp;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== tb/field_lines.sv ====
// Field wiring model with a short chatter burst
`timescale 1ns/10ps
`default_nettype none
module field_lines (
  input wire logic i_clk,
  input wire logic i_glitch,
  input wire logic [5:0] i_level,
  output logic [5:0] o_lines
);
  logic [2:0] left = 3'h0;
  // Burst of four cycles, shorter than one sample period
  always @(posedge i_clk) begin
    left <= i_glitch ? 3'h4 : left - {2'h0, left != 3'h0};
  end
  assign o_lines = (left != 3'h0) ? ~i_level : i_level;
endmodule
`default_nettype wire

// ==== tb/input_debounce_and_force_monitor.sv ====
// Checker of bus handshakes and status timing
`timescale 1ns/10ps
`default_nettype none
module input_debounce_and_force_monitor (
  input wire logic I_CLK_SYS, I_RST_N, I_AWVALID, I_WVALID,
  input wire logic I_BREADY, I_ARVALID, O_AWREADY, O_WREADY,
  input wire logic O_BVALID, O_ARREADY, O_RVALID,
  input wire logic [15:0] O_FILTERED_STATUS,
  input wire logic [31:0] O_RDATA
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  a_resv_zero: assert property (O_FILTERED_STATUS[15:6] == 10'h000)
    else $error("reserved status bits set");
  a_rdata_high: assert property (O_RVALID |-> O_RDATA[31:6] == 26'h0)
    else $error("upper read bits set");
  a_status_hold: assert property ($changed(O_FILTERED_STATUS) |=>
    $stable(O_FILTERED_STATUS) [*7]) else $error("status moved early");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read not answered");
  a_read_refuse: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while busy");
  a_write_refuse: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while busy");
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID &&
    O_WREADY |-> ##[1:2] O_BVALID) else $error("write not answered");
  a_write_done: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("response not released");
endmodule
bind input_debounce_and_force input_debounce_and_force_monitor u_mon (
  .I_CLK_SYS, .I_RST_N, .I_AWVALID, .I_WVALID, .I_BREADY, .I_ARVALID,
  .O_AWREADY, .O_WREADY, .O_BVALID, .O_ARREADY, .O_RVALID,
  .O_FILTERED_STATUS, .O_RDATA);
`default_nettype wire

// ==== tb/input_debounce_and_force_tb.sv ====
// Self-checking bench for the debounce and force block
`timescale 1ns/10ps
`default_nettype none
module input_debounce_and_force_tb;
  logic c = 0, rn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, g = 0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hf;
  logic [34:0] e;
  logic [1:0] qb[$], eb;
  wire [1:0] br, rr;
  logic [5:0] lv = 6'h00, ln, fv, fm;
  wire [15:0] st;
  wire awr, wr, bv, arr, rv;
  wire [31:0] rd;
  logic [34:0] q[$];
  int errors = 0, samples_checked = 0;
  always #5 c = ~c;
  field_lines u_field_lines (.i_clk(c), .i_glitch(g), .i_level(lv),
    .o_lines(ln));
  input_debounce_and_force #(.SAMPLE_CYCLES(8)) u_input_debounce_and_force (
    .I_CLK_SYS(c), .I_RST_N(rn), .I_INPUT_LINES(ln), .O_FILTERED_STATUS(st),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
    .I_WSTRB(ws), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(br), .O_BVALID(bv),
    .I_BREADY(bre), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rre));
  task end_sim;
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One bus transfer; a read notes its expected word
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    logic [1:0] r;
    tb = 0;
    // Offsets 0, 4 and 8 are mapped, any other answers a decode error
    r = (a[1:0] == 2'h0 && a <= 4'h8) ? 2'h0 : 2'h3;
    @(posedge c);
    if (w) begin
      {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
      qb.push_back(r);
    end else begin
      {ara, arv, rre} <= {a, 2'h3};
      q.push_back({a == 4'h0, r, d});
    end
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge c);
      ta = awv && awr || arv && arr;
      tw = wv && wr;
      tb = w ? bv : rv;
      @(posedge c);
      if (ta) {awv, arv} <= 2'h0;
      if (tw) wv <= 0;
      if (tb) {bre, rre} <= 2'h0;
    end
    if (!tb) begin
      errors++;
      $display("MISMATCH bus answer exp valid got none");
      end_sim;
    end
  endtask
  // Compares each read answer with the oldest note
  always @(posedge c) begin
    if (rv && rre) begin
      e = q.pop_front();
      samples_checked++;
      if ({rr, rd} !== e[33:0]) begin
        errors++;
        $display("MISMATCH rresp rdata exp %h got %h", e[33:0], {rr, rd});
      end
      if (e[34] && st !== e[15:0]) begin
        errors++;
        $display("MISMATCH status exp %h got %h", e[15:0], st);
      end
    end
    if (bv && bre) begin
      eb = qb.pop_front();
      samples_checked++;
      if (br !== eb) begin
        errors++;
        $display("MISMATCH bresp exp %h got %h", eb, br);
      end
    end
  end
  // Each pass starts from reset with random lines and force
  initial begin
    void'($urandom(32'h22d3));
    repeat (12) @(posedge c);
    rn <= 1;
    for (int k = 0; k < 3; k++) begin
      bus(0, 4'h4, 32'h0);
      bus(0, 4'h8, 32'h0);
      bus(0, 4'hc, 32'h0);
      @(posedge c) lv <= 6'($urandom);
      bus(0, 4'h0, 32'h0);
      repeat (24) @(posedge c);
      bus(0, 4'h0, {26'h0, lv});
      @(posedge c) g <= 1;
      @(posedge c) g <= 0;
      repeat (24) @(posedge c);
      bus(1, 4'h0, 32'hffffffff);
      bus(0, 4'h0, {26'h0, lv});
      fv = 6'($urandom);
      fm = 6'($urandom);
      bus(1, 4'h8, {26'h3ffffff, fv});
      bus(1, 4'h4, {26'h3ffffff, fm});
      bus(0, 4'h8, {26'h0, fv});
      @(posedge c) ws <= 4'h0;
      bus(1, 4'h4, 32'h0);
      bus(0, 4'h4, {26'h0, fm});
      @(posedge c) ws <= 4'hf;
      repeat (24) @(posedge c);
      bus(0, 4'h0, {26'h0, lv & ~fm | fv & fm});
      @(posedge c) {rn, lv} <= 7'h00;
      @(posedge c) rn <= 1;
    end
    end_sim;
  end
endmodule
`default_nettype wire
